// >>> hdl/alc_top.sv
// Per-channel result store, limit checker, service flags and wire test current control.
// Assumes settings are steady ports from software and result writes come from the converter on clk_in.
// Result writes and flag clears are single-cycle strobes on that clock.
//
// Contract
// - Every channel has its own check settings.
// - Check uses the channel's stored result.
// - Four boundaries; each channel picks two.
// - Select value k picks boundary k.
// - Area one: zero up to lower, inclusive.
// - Area two: above lower, up to upper.
// - Area three: above upper to top.
// - Larger selected boundary is the upper one.
// - Mode: never, on hit, or on miss.
// - Request only to configured enabled node.
// - Per-channel enable for wire test circuitry.
// - Select bit: zero sources, one sinks.
// - Range field picks one of four currents.
// - Extra mode: flag on every result write.
// - Write one clears flag; set wins.
`timescale 1ns/1ps
`default_nettype none
module alc_top
    import alc_pkg::*;
(
    input  wire logic                           clk_in,
    input  wire logic                           sys_rst_in,
    input  wire logic                           result_wr_in,
    input  wire logic [ALC_CH_W-1:0]            result_chan_in,
    input  wire logic [ALC_RES_W-1:0]           result_data_in,
    input  wire logic [ALC_CH_W-1:0]            result_rd_chan_in,
    input  wire logic [ALC_NBND*ALC_RES_W-1:0]  limit_boundary_reg_in,
    input  wire logic [ALC_NCH*ALC_SEL_W-1:0]   boundary_sel_a_in,
    input  wire logic [ALC_NCH*ALC_SEL_W-1:0]   boundary_sel_b_in,
    input  wire logic [ALC_NCH*ALC_LCC_W-1:0]   limit_check_ctrl_in,
    input  wire logic [ALC_NCH*ALC_NODE_W-1:0]  channel_node_pointer_in,
    input  wire logic [ALC_NCH-1:0]             channel_node_enable_in,
    input  wire logic [ALC_NCH-1:0]             flag_clear_in,
    input  wire logic [ALC_NCH-1:0]             wire_test_enable_in,
    input  wire logic [ALC_NCH-1:0]             test_current_select_in,
    input  wire logic [ALC_NCH*ALC_MR_W-1:0]    measure_range_select_in,
    output logic [ALC_RES_W-1:0]                result_rd_data_out,
    output logic [ALC_NCH-1:0]                  module_service_flags_out,
    output logic [ALC_NNODE-1:0]                node_request_out,
    output logic                                check_done_out,
    output logic [ALC_CH_W-1:0]                 check_chan_out,
    output logic [1:0]                          check_area_out,
    output logic [ALC_NCH-1:0]                  source_enable_out,
    output logic [ALC_NCH-1:0]                  sink_enable_out,
    output logic [ALC_NCH*ALC_MR_W-1:0]         measure_range_out
);

    // Picks one two-bit field of a packed per-channel vector.
    // Channel n owns bits [2n+1:2n].
    function automatic logic [1:0] alc_field2(input logic [ALC_NCH*2-1:0] vec, input logic [ALC_CH_W-1:0] ch);
        alc_field2 = vec[ch*2 +: 2];
    endfunction

    // Picks boundary k from the packed boundary set.
    // Boundary k owns bits [10k+9:10k].
    function automatic logic [ALC_RES_W-1:0] alc_bound(input logic [ALC_NBND*ALC_RES_W-1:0] set,
                                                       input logic [ALC_SEL_W-1:0] k);
        alc_bound = set[k*ALC_RES_W +: ALC_RES_W];
    endfunction

    // Stored conversion results, one word per channel.
    // The check reads this word, not the input.
    logic [ALC_RES_W-1:0] channel_result_reg [ALC_NCH];
    logic [ALC_RES_W-1:0] next_result_wdata;
    logic                 next_result_we;

    // Check stage: a write is checked one cycle later from the stored word.
    // The channel is held so the report can name it.
    logic                 chk_pend;
    logic [ALC_CH_W-1:0]  chk_ch;

    // Next values of the check stage.
    logic                 next_chk_pend;
    logic [ALC_CH_W-1:0]  next_chk_ch;

    // Flags, requests and check report.
    // Flags are sticky; requests and done are pulses.
    logic [ALC_NCH-1:0]   flags;
    logic [ALC_NNODE-1:0] req;
    logic                 done;
    logic [ALC_CH_W-1:0]  done_ch;
    logic [1:0]           done_area;

    // Next values of the flags and report.
    logic [ALC_NCH-1:0]   next_flags;
    logic [ALC_NNODE-1:0] next_req;
    logic                 next_done;
    logic [ALC_CH_W-1:0]  next_done_ch;
    logic [1:0]           next_done_area;

    // Read port and wire test drive.
    logic [ALC_RES_W-1:0]        rd_data;
    logic [ALC_NCH-1:0]          src_en;
    logic [ALC_NCH-1:0]          snk_en;
    logic [ALC_NCH*ALC_MR_W-1:0] range;

    // Next values of the read port and drive.
    logic [ALC_RES_W-1:0]        next_rd_data;
    logic [ALC_NCH-1:0]          next_src_en;
    logic [ALC_NCH-1:0]          next_snk_en;
    logic [ALC_NCH*ALC_MR_W-1:0] next_range;

    // Comparator operands for the channel being checked.
    logic [ALC_RES_W-1:0]  chk_result;
    logic [ALC_RES_W-1:0]  chk_bound_a;
    logic [ALC_RES_W-1:0]  chk_bound_b;

    // Decoded control field of that channel.
    logic [ALC_LCC_W-1:0]  chk_lcc;
    alc_area_t             chk_area;
    alc_mode_t             chk_mode;
    alc_area_t             chk_target;

    // The stored result and the channel's own selectors feed the comparator.
    // Settings are read in the check cycle.
    always_comb
    begin
        chk_result  = channel_result_reg[chk_ch];
        chk_bound_a = alc_bound(limit_boundary_reg_in, alc_field2(boundary_sel_a_in, chk_ch));
        chk_bound_b = alc_bound(limit_boundary_reg_in, alc_field2(boundary_sel_b_in, chk_ch));
        chk_lcc     = limit_check_ctrl_in[chk_ch*ALC_LCC_W +: ALC_LCC_W];
        chk_mode    = alc_mode_t'(chk_lcc[ALC_LCC_MODE_LSB +: 2]);
        chk_target  = alc_area_t'(chk_lcc[ALC_LCC_AREA_LSB +: 2]);
    end

    // One comparator serves all channels, one check per cycle.
    alc_limit_cmp u_cmp
    (
        .result_in  (chk_result),
        .bound_a_in (chk_bound_a),
        .bound_b_in (chk_bound_b),
        .area_out   (chk_area)
    );

    // Result store write decode.
    // Every strobe is taken; nothing is refused.
    always_comb
    begin
        next_result_we    = result_wr_in;
        next_result_wdata = result_data_in;
    end

    // Result store: one word per channel, cleared at reset.
    // A write lands at the edge that samples its strobe.
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            for (int i = 0; i < ALC_NCH; i++)
            begin
                channel_result_reg[i] <= ALC_RESULT_RST;
            end
        end
        else if (next_result_we)
        begin
            channel_result_reg[result_chan_in] <= next_result_wdata;
        end
    end

    // Each result write schedules one check of that channel.
    // Back-to-back writes are each checked.
    always_comb
    begin
        next_chk_pend = result_wr_in;
        next_chk_ch   = result_wr_in ? result_chan_in : chk_ch;
    end

    // Check stage registers.
    // Reset drops a pending check, so no stale flag follows.
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            chk_pend <= 1'b0;
            chk_ch   <= '0;
        end
        else
        begin
            chk_pend <= next_chk_pend;
            chk_ch   <= next_chk_ch;
        end
    end

    // Flag set from the mode, write-one clear, and one-cycle node request.
    // A disabled node still sets the flag, for polling.
    always_comb
    begin
        logic set_now;
        logic [ALC_NODE_W-1:0] node;
        set_now        = 1'b0;
        node           = alc_field2(channel_node_pointer_in, chk_ch);
        next_req       = ALC_REQ_RST;
        next_done      = chk_pend;
        next_done_ch   = chk_pend ? chk_ch : done_ch;
        next_done_area = chk_pend ? chk_area : done_area;
        // Only a running check may set a flag.
        if (chk_pend)
        begin
            case (chk_mode)
                ALC_MODE_NEVER: set_now = 1'b0;
                ALC_MODE_HIT:   set_now = (chk_area == chk_target);
                ALC_MODE_MISS:  set_now = (chk_area != chk_target);
                ALC_MODE_WRITE: set_now = 1'b1;
                default:        set_now = 1'b0;
            endcase
        end
        // Clear first, so a set below overrides it.
        next_flags = flags & ~flag_clear_in;
        if (set_now)
        begin
            next_flags[chk_ch] = 1'b1; // Set wins over a clear in the same cycle.
            if (channel_node_enable_in[chk_ch])
            begin
                next_req[node] = 1'b1;
            end
        end
    end

    // Flag, request and report registers.
    // Requests and done stand for one cycle.
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            flags     <= ALC_FLAGS_RST;
            req       <= ALC_REQ_RST;
            done      <= 1'b0;
            done_ch   <= '0;
            done_area <= ALC_AREA_NONE;
        end
        else
        begin
            flags     <= next_flags;
            req       <= next_req;
            done      <= next_done;
            done_ch   <= next_done_ch;
            done_area <= next_done_area;
        end
    end

    // Registered read of a stored result, and per-channel test current drive.
    // Source and sink never drive one channel at once.
    always_comb
    begin
        next_rd_data = channel_result_reg[result_rd_chan_in];
        for (int i = 0; i < ALC_NCH; i++)
        begin
            next_src_en[i] = wire_test_enable_in[i] && (test_current_select_in[i] == ALC_PATH_SOURCE);
            next_snk_en[i] = wire_test_enable_in[i] && (test_current_select_in[i] == ALC_PATH_SINK);
            // A disabled channel also shows range zero, the field value of the area one current.
            next_range[i*ALC_MR_W +: ALC_MR_W] = wire_test_enable_in[i] ?
                measure_range_select_in[i*ALC_MR_W +: ALC_MR_W] : 2'h0;
        end
    end

    // Read data and test current registers.
    // The drive follows its settings one edge later.
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            rd_data <= ALC_RESULT_RST;
            src_en  <= '0;
            snk_en  <= '0;
            range   <= '0;
        end
        else
        begin
            rd_data <= next_rd_data;
            src_en  <= next_src_en;
            snk_en  <= next_snk_en;
            range   <= next_range;
        end
    end

    // Every output comes straight from a flip-flop.
    assign result_rd_data_out       = rd_data;
    assign module_service_flags_out = flags;
    assign node_request_out         = req;

    // Check report.
    assign check_done_out           = done;
    assign check_chan_out           = done_ch;
    assign check_area_out           = done_area;

    // Test current drive.
    assign source_enable_out        = src_en;
    assign sink_enable_out          = snk_en;
    assign measure_range_out        = range;

endmodule
`default_nettype wire

// >>> hdl/alc_pkg.sv
// Shared constants for the per-channel limit checker and wire test control.
// Assumes a single synchronous clock domain and no register bus; all settings arrive as ports.
package alc_pkg;

    // Channel count, result width and boundary set.
    localparam int ALC_NCH    = 16;
    localparam int ALC_CH_W   = 4;
    localparam int ALC_RES_W  = 10;
    localparam int ALC_NBND   = 4;
    localparam int ALC_SEL_W  = 2;
    localparam int ALC_NODE_W = 2;
    localparam int ALC_NNODE  = 4;
    localparam int ALC_LCC_W  = 4;
    localparam int ALC_MR_W   = 2;

    // Lowest code of the measuring range.
    localparam logic [ALC_RES_W-1:0] ALC_CODE_ZERO = 10'h000;

    // Field positions inside one channel's limit check control field.
    localparam int ALC_LCC_AREA_LSB = 0;
    localparam int ALC_LCC_MODE_LSB = 2;

    // Flag behaviour held in the mode part of the control field.
    typedef enum logic [1:0] {
        ALC_MODE_NEVER = 2'h0,
        ALC_MODE_HIT   = 2'h1,
        ALC_MODE_MISS  = 2'h2,
        ALC_MODE_WRITE = 2'h3
    } alc_mode_t;

    // Area codes produced by the comparator and used as targets.
    typedef enum logic [1:0] {
        ALC_AREA_NONE  = 2'h0,
        ALC_AREA_ONE   = 2'h1,
        ALC_AREA_TWO   = 2'h2,
        ALC_AREA_THREE = 2'h3
    } alc_area_t;

    // Test current path select values.
    localparam logic ALC_PATH_SOURCE = 1'h0;
    localparam logic ALC_PATH_SINK   = 1'h1;

    // Nominal test current per measuring area; field value 0 is area 1.
    localparam real ALC_ITEST_AREA4_MA = 0.2666;
    localparam real ALC_ITEST_AREA3_MA = 0.0444;
    localparam real ALC_ITEST_AREA2_MA = 0.0074;
    localparam real ALC_ITEST_AREA1_MA = 0.0012;

    // Values after reset.
    localparam logic [ALC_NCH-1:0]   ALC_FLAGS_RST  = 16'h0000;
    localparam logic [ALC_NNODE-1:0] ALC_REQ_RST    = 4'h0;
    localparam logic [ALC_RES_W-1:0] ALC_RESULT_RST = 10'h000;

endpackage

// >>> hdl/alc_limit_cmp.sv
// Classifies one result against two boundaries into areas one, two or three.
// Assumes results and boundaries share one width; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module alc_limit_cmp
    import alc_pkg::*;
(
    input  wire logic [ALC_RES_W-1:0] result_in,
    input  wire logic [ALC_RES_W-1:0] bound_a_in,
    input  wire logic [ALC_RES_W-1:0] bound_b_in,
    output var alc_area_t             area_out
);

    logic [ALC_RES_W-1:0] lower;
    logic [ALC_RES_W-1:0] upper;

    // The larger boundary is the upper one whichever selector chose it.
    always_comb
    begin
        if (bound_a_in > bound_b_in)
        begin
            upper = bound_a_in;
            lower = bound_b_in;
        end
        else
        begin
            upper = bound_b_in; // Equal values collapse area two to nothing.
            lower = bound_a_in;
        end
    end

    // Area one includes the lower boundary, area two the upper one.
    always_comb
    begin
        if (result_in <= lower)
        begin
            area_out = ALC_AREA_ONE;
        end
        else if (result_in <= upper)
        begin
            area_out = ALC_AREA_TWO;
        end
        else
        begin
            area_out = ALC_AREA_THREE; // Runs to the top code of the result width.
        end
    end

endmodule
`default_nettype wire

// >>> sim/alc_top_props.sv
// Checker for the limit checker and wire test block, bound to its top module.
// Assumes one clock and settings held steady while a check is running.
`timescale 1ns/1ps
`default_nettype none
module alc_props_chk
    import alc_pkg::*;
(
    input wire logic                          clk_in,
    input wire logic                          sys_rst_in,
    input wire logic                          result_wr_in,
    input wire logic [ALC_CH_W-1:0]           result_chan_in,
    input wire logic [ALC_RES_W-1:0]          result_data_in,
    input wire logic [ALC_NBND*ALC_RES_W-1:0] limit_boundary_reg_in,
    input wire logic [ALC_NCH*ALC_SEL_W-1:0]  boundary_sel_a_in,
    input wire logic [ALC_NCH*ALC_SEL_W-1:0]  boundary_sel_b_in,
    input wire logic [ALC_NCH*ALC_LCC_W-1:0]  limit_check_ctrl_in,
    input wire logic [ALC_NCH*ALC_NODE_W-1:0] channel_node_pointer_in,
    input wire logic [ALC_NCH-1:0]            channel_node_enable_in,
    input wire logic [ALC_NCH-1:0]            flag_clear_in,
    input wire logic [ALC_NCH-1:0]            wire_test_enable_in,
    input wire logic [ALC_NCH-1:0]            test_current_select_in,
    input wire logic [ALC_NCH-1:0]            module_service_flags_out,
    input wire logic [ALC_NNODE-1:0]          node_request_out,
    input wire logic                          check_done_out,
    input wire logic [ALC_CH_W-1:0]           check_chan_out,
    input wire logic [1:0]                    check_area_out,
    input wire logic [ALC_NCH-1:0]            source_enable_out,
    input wire logic [ALC_NCH-1:0]            sink_enable_out
);
    logic [ALC_RES_W-1:0] bnd_a;
    logic [ALC_RES_W-1:0] bnd_b;
    logic [1:0]           exp_area;
    logic [ALC_LCC_W-1:0] ctrl;
    logic                 exp_set;
    logic [ALC_NNODE-1:0] exp_req;
    logic [ALC_NCH-1:0]   src_exp;
    logic [ALC_NCH-1:0]   snk_exp;

    // Predicts area, flag and request for the result offered in this cycle.
    always_comb
    begin
        bnd_a = limit_boundary_reg_in[ALC_RES_W*boundary_sel_a_in[ALC_SEL_W*result_chan_in +: ALC_SEL_W] +: ALC_RES_W];
        bnd_b = limit_boundary_reg_in[ALC_RES_W*boundary_sel_b_in[ALC_SEL_W*result_chan_in +: ALC_SEL_W] +: ALC_RES_W];
        if (result_data_in <= ((bnd_a < bnd_b) ? bnd_a : bnd_b))
            exp_area = 2'h1;
        else if (result_data_in <= ((bnd_a < bnd_b) ? bnd_b : bnd_a))
            exp_area = 2'h2;
        else
            exp_area = 2'h3;
        ctrl = limit_check_ctrl_in[ALC_LCC_W*result_chan_in +: ALC_LCC_W];
        case (ctrl[3:2])
            ALC_MODE_HIT:   exp_set = (ctrl[1:0] == exp_area);
            ALC_MODE_MISS:  exp_set = (ctrl[1:0] != exp_area);
            ALC_MODE_WRITE: exp_set = 1'h1;
            default:        exp_set = 1'h0;
        endcase
        exp_req = '0;
        exp_req[channel_node_pointer_in[ALC_NODE_W*result_chan_in +: ALC_NODE_W]] =
            exp_set & channel_node_enable_in[result_chan_in];
    end

    // Test current paths expected one edge after the settings.
    assign src_exp = wire_test_enable_in & ~test_current_select_in;
    assign snk_exp = wire_test_enable_in & test_current_select_in;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // A write taken on one edge, followed by the edge that runs the check.
    sequence s_taken;
        result_wr_in ##1 1'h1;
    endsequence

    a_done_after_write: assert property (s_taken |=> check_done_out)
        else $error("check not done two cycles after a write");
    a_done_cause: assert property (check_done_out |-> $past(result_wr_in, 2))
        else $error("check done without a write");
    a_chan_follows: assert property (result_wr_in |-> ##2 check_chan_out == $past(result_chan_in, 2))
        else $error("checked channel differs from written channel");
    a_area_class: assert property (result_wr_in |-> ##2
        check_area_out == $past(exp_area, 2))
        else $error("wrong area for result");
    a_flag_and_req: assert property (result_wr_in && exp_set |-> ##2
        module_service_flags_out[$past(result_chan_in, 2)]
        && ((node_request_out & $past(exp_req, 2)) == $past(exp_req, 2)))
        else $error("flag or request missing after check");
    a_req_cause: assert property (node_request_out != '0 |-> check_done_out)
        else $error("request without a check");
    a_flag_rise: assert property ((module_service_flags_out & ~$past(module_service_flags_out)) != '0
        |-> check_done_out)
        else $error("flag set without a check");
    a_flag_clear: assert property (flag_clear_in != '0 && !$past(result_wr_in)
        |=> (module_service_flags_out & $past(flag_clear_in)) == '0)
        else $error("flag not cleared");
    a_path_follow: assert property (!sys_rst_in |=> source_enable_out == $past(src_exp)
        && sink_enable_out == $past(snk_exp))
        else $error("test current path wrong");
endmodule

bind alc_top alc_props_chk u_chk
(
    .clk_in, .sys_rst_in, .result_wr_in, .result_chan_in, .result_data_in, .limit_boundary_reg_in,
    .boundary_sel_a_in, .boundary_sel_b_in, .limit_check_ctrl_in, .channel_node_pointer_in,
    .channel_node_enable_in, .flag_clear_in, .wire_test_enable_in, .test_current_select_in,
    .module_service_flags_out, .node_request_out, .check_done_out, .check_chan_out, .check_area_out,
    .source_enable_out, .sink_enable_out
);
`default_nettype wire

// >>> sim/alc_sensor_model.sv
// Behavioural sensor on the analog inputs, answering the test current drive.
// Assumes 1024 codes over a 5 V reference; the pad settles after five time constants.
`timescale 1ns/1ps
`default_nettype none
module alc_sensor_model
    import alc_pkg::*;
#(
    parameter int TAU = 2
)
(
    input  wire logic        clk_in,
    input  wire logic [15:0] source_enable_in,
    input  wire logic [15:0] sink_enable_in,
    input  wire logic [31:0] range_in,
    input  wire logic [3:0]  chan_in,
    output logic      [9:0]  code_out
);
    int  settle = 0;
    real v_open;
    real r_kohm;
    real i_ma;
    real v_pad;

    // Counts cycles of test current on the probed channel.
    always @(posedge clk_in)
        settle <= (source_enable_in[chan_in] | sink_enable_in[chan_in]) ? settle + 1 : 0;

    // Open voltage and impedance per channel, then the loaded pad voltage.
    always_comb
    begin
        v_open = (chan_in == 4'h3) ? 1.0 : (chan_in == 4'h7) ? 4.0 : (chan_in == 4'h9) ? 1.5 : 2.5;
        r_kohm = (chan_in == 4'h3) ? 2.0 : (chan_in == 4'h7) ? 5000.0 : (chan_in == 4'h9) ? 0.1 : 10.0;
        case (range_in[2*chan_in +: 2])
            2'h0:    i_ma = ALC_ITEST_AREA1_MA;
            2'h1:    i_ma = ALC_ITEST_AREA2_MA;
            2'h2:    i_ma = ALC_ITEST_AREA3_MA;
            default: i_ma = ALC_ITEST_AREA4_MA;
        endcase
        v_pad = v_open;
        if (settle >= 5 * TAU && source_enable_in[chan_in])
            v_pad = v_open + i_ma * r_kohm;
        else if (settle >= 5 * TAU && sink_enable_in[chan_in])
            v_pad = v_open - i_ma * r_kohm;
        v_pad = (v_pad < 0.0) ? 0.0 : (v_pad > 4.99) ? 4.99 : v_pad;
        code_out = 10'(int'(v_pad * 1024.0 / 5.0));
    end
endmodule
`default_nettype wire

// >>> sim/test_alc_top.sv
// Self-checking bench for the limit checker and wire test block.
// Assumes the sensor model on the far side and inputs driven at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module test_alc_top
    import alc_pkg::*;
;
    logic        clk_in = 1'h0;
    logic        sys_rst_in = 1'h1;
    logic        result_wr_in = 1'h0;
    logic [3:0]  result_chan_in = 4'h0;
    logic [9:0]  result_data_in = 10'h000;
    logic [3:0]  result_rd_chan_in = 4'h0;
    logic [39:0] limit_boundary_reg_in = {10'h0c8, 10'h064, 10'h12c, 10'h0c8};
    logic [31:0] boundary_sel_a_in = 32'h0000_0800;
    logic [31:0] boundary_sel_b_in = 32'h0000_3400;
    logic [63:0] limit_check_ctrl_in = 64'h0;
    logic [31:0] channel_node_pointer_in = 32'h0000_0800;
    logic [15:0] channel_node_enable_in = 16'h0020;
    logic [15:0] flag_clear_in = 16'h0000;
    logic [15:0] wire_test_enable_in = 16'h0000;
    logic [15:0] test_current_select_in = 16'h0000;
    logic [31:0] measure_range_select_in = 32'h0;
    logic [9:0]  result_rd_data_out;
    logic [15:0] module_service_flags_out;
    logic [3:0]  node_request_out;
    logic        check_done_out;
    logic [3:0]  check_chan_out;
    logic [1:0]  check_area_out;
    logic [15:0] source_enable_out;
    logic [15:0] sink_enable_out;
    logic [31:0] measure_range_out;
    logic [9:0]  sensor_code;
    int          n_errors = 0;
    int          checks = 0;

    // Clock of 10 ns period.
    always #5 clk_in = ~clk_in;

    alc_top u_dut (.clk_in, .sys_rst_in, .result_wr_in, .result_chan_in, .result_data_in, .result_rd_chan_in,
        .limit_boundary_reg_in, .boundary_sel_a_in, .boundary_sel_b_in, .limit_check_ctrl_in,
        .channel_node_pointer_in, .channel_node_enable_in, .flag_clear_in, .wire_test_enable_in,
        .test_current_select_in, .measure_range_select_in, .result_rd_data_out, .module_service_flags_out,
        .node_request_out, .check_done_out, .check_chan_out, .check_area_out, .source_enable_out,
        .sink_enable_out, .measure_range_out);
    alc_sensor_model #(.TAU(2)) u_sensor (.clk_in, .source_enable_in(source_enable_out),
        .sink_enable_in(sink_enable_out), .range_in(measure_range_out), .chan_in(result_rd_chan_in),
        .code_out(sensor_code));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Writes one result, checks the answer two cycles on, then clears the flag.
    task automatic wr(input logic [3:0] ch, input logic [9:0] d, input logic [1:0] area, input logic fl,
        input logic [3:0] req);
        @(negedge clk_in);
        result_wr_in = 1'h1;
        result_chan_in = ch;
        result_data_in = d;
        result_rd_chan_in = ch;
        @(negedge clk_in);
        result_wr_in = 1'h0;
        @(negedge clk_in);
        chk(check_done_out, 1'h1);
        chk(check_chan_out, ch);
        chk(check_area_out, area);
        chk(module_service_flags_out[ch], fl);
        chk(node_request_out, req);
        chk(result_rd_data_out, d);
        flag_clear_in = 16'h0001 << ch;
        @(negedge clk_in);
        flag_clear_in = 16'h0000;
        chk(module_service_flags_out[ch], 1'h0);
    endtask

    // Boundary edges on two channels with their own boundary pairs.
    task automatic t_areas();
        logic [9:0] d [8] = '{10'h000, 10'h064, 10'h065, 10'h12c, 10'h12d, 10'h3ff, 10'h0c8, 10'h0c9};
        logic [1:0] a [8] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1, 2'h3};
        limit_check_ctrl_in[20 +: 8] = 8'h66;
        for (int i = 0; i < 8; i++)
            wr(i < 6 ? 4'h5 : 4'h6, d[i], a[i], a[i] == 2'h2, (i < 6 && a[i] == 2'h2) ? 4'h4 : 4'h0);
    endtask

    // Every flag mode against a hit and a miss, then with the node disabled.
    task automatic t_modes();
        for (int m = 0; m < 4; m++)
        begin
            limit_check_ctrl_in[20 +: 4] = {m[1:0], 2'h2};
            wr(4'h5, 10'h0c8, 2'h2, m[0], m[0] ? 4'h4 : 4'h0);
            wr(4'h5, 10'h032, 2'h1, m[1], m[1] ? 4'h4 : 4'h0);
        end
        channel_node_enable_in = 16'h0000;
        wr(4'h5, 10'h032, 2'h1, 1'h1, 4'h0);
        channel_node_enable_in = 16'h0020;
        @(negedge clk_in);
        result_wr_in = 1'h1;
        @(negedge clk_in);
        result_wr_in = 1'h0;
        flag_clear_in = 16'h0020;
        @(negedge clk_in);
        flag_clear_in = 16'h0000;
        chk(module_service_flags_out[5], 1'h1);
    endtask

    // Software measures, applies test current, measures again and judges.
    task automatic t_wire(input logic [3:0] ch, input logic [1:0] rng, input logic [1:0] cls);
        logic [9:0] c0;
        real        r_k;
        real        i_ma [4] = '{ALC_ITEST_AREA1_MA, ALC_ITEST_AREA2_MA, ALC_ITEST_AREA3_MA, ALC_ITEST_AREA4_MA};
        result_rd_chan_in = ch;
        @(negedge clk_in);
        c0 = sensor_code;
        test_current_select_in[ch] = (c0 >= 10'h200);
        measure_range_select_in[2*ch +: 2] = rng;
        wire_test_enable_in[ch] = 1'h1;
        repeat (12) @(negedge clk_in);
        chk(source_enable_out[ch], !test_current_select_in[ch]);
        chk(sink_enable_out[ch], test_current_select_in[ch]);
        chk(measure_range_out[2*ch +: 2], rng);
        wr(ch, sensor_code, sensor_code <= 10'h0c8 ? 2'h1 : 2'h3, 1'h0, 4'h0);
        r_k = ((result_rd_data_out > c0) ? result_rd_data_out - c0 : c0 - result_rd_data_out) * 5.0 / 1024.0 / i_ma[rng];
        chk(r_k > 400.0 ? 2'h1 : r_k < 0.5 ? 2'h2 : 2'h0, cls);
        wire_test_enable_in[ch] = 1'h0;
        @(negedge clk_in);
        chk(source_enable_out[ch] | sink_enable_out[ch], 1'h0);
        chk(measure_range_out[2*ch +: 2], 2'h0);
    endtask

    task automatic end_sim();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence after a reset of 16 cycles.
    initial
    begin
        repeat (16) @(negedge clk_in);
        sys_rst_in = 1'h0;
        chk(module_service_flags_out, 16'h0000);
        t_areas();
        t_modes();
        t_wire(4'h3, 2'h3, 2'h0);
        t_wire(4'h7, 2'h0, 2'h1);
        t_wire(4'h9, 2'h3, 2'h2);
        end_sim();
    end

    // Cuts a hang short well beyond the some 140 cycles the tests need.
    initial
    begin
        repeat (4000) @(posedge clk_in);
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
